// ===== rtl/sbs_pkg.sv
/*
 servo burst sequencer word execution: shared constants and types.
 assumes one clock domain and an axi4-lite register port.
*/
package sbs_pkg;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned WORD_W  = 25;
  localparam int unsigned TMR_W   = 10;
  localparam int unsigned SHIFT_W = 16;

  // instruction field positions
  localparam int unsigned SEL1_BIT = 24;
  localparam int unsigned WDIS_BIT = 23;
  localparam int unsigned GRAY_BIT = 22;
  localparam int unsigned IDX_BIT  = 21;
  localparam int unsigned SECT_BIT = 20;
  localparam int unsigned ACQ_BIT  = 19;
  localparam int unsigned BT_HI    = 18;
  localparam int unsigned BT_LO    = 16;
  localparam int unsigned IRQ_BIT  = 15;
  localparam int unsigned BA_HI    = 14;
  localparam int unsigned BA_LO    = 10;
  localparam int unsigned TL_HI    = 9;

  typedef enum logic [2:0] {
    BT_NEVER   = 3'h0,
    BT_MISSING = 3'h1,
    BT_SEARCH  = 3'h2,
    BT_MARK    = 3'h3,
    BT_FLAG    = 3'h4,
    BT_BRBIT   = 3'h5,
    BT_BRTIMED = 3'h6,
    BT_ALWAYS  = 3'h7
  } sbs_btype_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } sbs_state_t;

  // register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_GRAY  = 8'h08;
  localparam logic [7:0] REG_INDEX = 8'h0c;
  localparam logic [7:0] REG_PADDR = 8'h10;
  localparam logic [7:0] REG_PDATA = 8'h14;

  localparam int unsigned CTRL_RUN    = 0;
  localparam int unsigned CTRL_BRANCH = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/sbs_cond_if.sv
/*
 branch condition carrier between sequencer and evaluator.
 assumes all members sampled in the sequencer clock domain.
*/
`timescale 1ns/1ps
interface sbs_cond_if;
  logic [2:0] btype;
  logic       tmr_zero;
  logic       missing_mark;
  logic       search_window;
  logic       servo_timing_mark;
  logic       flag_bit;
  logic       branch_bit;
  logic       take;
  modport eval (input btype, tmr_zero, missing_mark, search_window,
                servo_timing_mark, flag_bit, branch_bit, output take);
  modport seq (output btype, tmr_zero, missing_mark, search_window,
               servo_timing_mark, flag_bit, branch_bit, input take);
endinterface // sbs_cond_if

// ===== rtl/sbs_branch_eval.sv
/*
 branch condition evaluator for the executing word.
 assumes inputs stable within the cycle; output is combinational.
*/
`timescale 1ns/1ps
module sbs_branch_eval (
  sbs_cond_if.eval c
);
  always_comb begin
    case (c.btype)
      sbs_pkg::BT_NEVER:   c.take = 1'b0;
      sbs_pkg::BT_MISSING: c.take = c.missing_mark;
      sbs_pkg::BT_SEARCH:  c.take = c.search_window;
      sbs_pkg::BT_MARK:    c.take = c.servo_timing_mark & c.search_window;
      sbs_pkg::BT_FLAG:    c.take = c.flag_bit;
      sbs_pkg::BT_BRBIT:   c.take = c.branch_bit;
      sbs_pkg::BT_BRTIMED: c.take = c.branch_bit & c.tmr_zero;
      default:             c.take = 1'b1;
    endcase
  end
endmodule // sbs_branch_eval

// ===== rtl/sbs_word_exec.sv
/*
 servo burst sequencer word execution: program store, sequencer, pins, axi4-lite slave.
 assumes synchronous inputs, a one-cycle sync_bit_clock pulse per recovered bit,
 and a microprogram that keeps its own timing rules.
*/
`timescale 1ns/1ps
module sbs_word_exec #(
  parameter int unsigned SHIFT_W = sbs_pkg::SHIFT_W
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               missing_mark_latch,
  input  wire logic               search_window,
  input  wire logic               servo_timing_mark,
  input  wire logic               flag_bit,
  input  wire logic               sync_bit_clock,
  input  wire logic               sync_bit_data,
  input  wire logic               write_gate_req,
  output logic                    extra_select_one_pin,
  output logic                    qualified_write_gate,
  output logic                    servo_sector_pin,
  output logic                    acq_start,
  output logic                    dsp_irq
);
  localparam int unsigned AW = sbs_pkg::ADDR_W;
  localparam int unsigned WW = sbs_pkg::WORD_W;
  localparam int unsigned TW = sbs_pkg::TMR_W;

  logic [WW-1:0]      prog_mem [2**AW];
  logic [WW-1:0]      word;
  logic [AW-1:0]      pc;
  logic [TW-1:0]      tmr;
  sbs_pkg::sbs_state_t st;
  logic [1:0]         ctrl;
  logic [AW-1:0]      paddr;
  logic [SHIFT_W-1:0] gray_sr;
  logic [SHIFT_W-1:0] index_sr;
  logic               first;
  logic [7:0]         aw_addr;
  logic               aw_held;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               w_held;
  logic               ld;
  logic [AW-1:0]      next_pc;
  logic [WW-1:0]      next_word;
  logic               running;
  logic               do_write;

  sbs_cond_if cond ();

  sbs_branch_eval u_eval (
    .c (cond.eval)
  );

  // field of a word as a bit, used for both current and next word
  function automatic logic wbit(input logic [WW-1:0] w, input int unsigned b);
    return w[b];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == sbs_pkg::REG_CTRL || a == sbs_pkg::REG_STAT ||
           a == sbs_pkg::REG_GRAY || a == sbs_pkg::REG_INDEX ||
           a == sbs_pkg::REG_PADDR || a == sbs_pkg::REG_PDATA;
  endfunction

  assign running                = st == sbs_pkg::ST_RUN;
  assign cond.btype             = word[sbs_pkg::BT_HI:sbs_pkg::BT_LO];
  assign cond.tmr_zero          = tmr == '0;
  assign cond.missing_mark      = missing_mark_latch;
  assign cond.search_window     = search_window;
  assign cond.servo_timing_mark = servo_timing_mark;
  assign cond.flag_bit          = flag_bit;
  assign cond.branch_bit        = ctrl[sbs_pkg::CTRL_BRANCH];

  // next instruction selection; branch beats timeout
  always_comb begin
    ld      = 1'b0;
    next_pc = pc;
    if (!running && ctrl[sbs_pkg::CTRL_RUN]) begin
      ld      = 1'b1;
      next_pc = '0;
    end else if (running && ctrl[sbs_pkg::CTRL_RUN]) begin
      if (cond.take) begin
        ld      = 1'b1;
        next_pc = word[sbs_pkg::BA_HI:sbs_pkg::BA_LO];
      end else if (tmr == '0) begin
        ld      = 1'b1;
        next_pc = AW'(pc + 1'b1);
      end
    end
  end

  assign next_word = prog_mem[next_pc];

  // sequencer state, pc, word and timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st    <= sbs_pkg::ST_IDLE;
      pc    <= '0;
      word  <= '0;
      tmr   <= '0;
      first <= 1'b0;
    end else if (ce) begin
      first <= ld;
      if (!ctrl[sbs_pkg::CTRL_RUN]) begin
        st   <= sbs_pkg::ST_IDLE;
        word <= '0;
        tmr  <= '0;
      end else if (ld) begin
        st   <= sbs_pkg::ST_RUN;
        pc   <= next_pc;
        word <= next_word;
        tmr  <= next_word[sbs_pkg::TL_HI:0];
      end else begin
        tmr  <= tmr - 1'b1;
      end
    end
  end

  // pins set together with the word they belong to
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extra_select_one_pin <= 1'b0;
      servo_sector_pin     <= 1'b0;
      acq_start            <= 1'b0;
      dsp_irq              <= 1'b0;
    end else if (ce) begin
      if (!ctrl[sbs_pkg::CTRL_RUN]) begin
        extra_select_one_pin <= 1'b0;
        servo_sector_pin     <= 1'b0;
        acq_start            <= 1'b0;
        dsp_irq              <= 1'b0;
      end else if (ld) begin
        extra_select_one_pin <= wbit(next_word, sbs_pkg::SEL1_BIT);
        servo_sector_pin     <= wbit(next_word, sbs_pkg::SECT_BIT);
        // only a low-to-high step between words starts acquisition
        acq_start <= wbit(next_word, sbs_pkg::ACQ_BIT) &
                     ~(running & wbit(word, sbs_pkg::ACQ_BIT));
        dsp_irq   <= wbit(next_word, sbs_pkg::IRQ_BIT);
      end else begin
        acq_start <= 1'b0;
        dsp_irq   <= 1'b0;
      end
    end
  end

  // write gate qualified a clock late: pin is registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qualified_write_gate <= 1'b0;
    end else if (ce) begin
      qualified_write_gate <= write_gate_req &
                              ~(running & wbit(word, sbs_pkg::WDIS_BIT));
    end
  end

  // shift windows; a bit clock outside the window is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gray_sr  <= '0;
      index_sr <= '0;
    end else if (ce && running && sync_bit_clock) begin
      if (wbit(word, sbs_pkg::GRAY_BIT)) begin
        gray_sr <= {gray_sr[SHIFT_W-2:0], sync_bit_data};
      end
      if (wbit(word, sbs_pkg::IDX_BIT)) begin
        index_sr <= {index_sr[SHIFT_W-2:0], sync_bit_data};
      end
    end
  end

  // axi write channels taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_held; // ready never waits for valid to drop
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_wready <= !w_held;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // register writes; program store written word-wide through paddr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl         <= sbs_pkg::CTRL_RST;
      paddr        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sbs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? sbs_pkg::RESP_OKAY : sbs_pkg::RESP_SLVERR;
        if (aw_addr == sbs_pkg::REG_CTRL && w_strb[0]) begin
          ctrl <= w_data[1:0];
        end else if (aw_addr == sbs_pkg::REG_PADDR && w_strb[0]) begin
          paddr <= w_data[AW-1:0];
        end else if (aw_addr == sbs_pkg::REG_PDATA) begin
          paddr <= AW'(paddr + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && do_write && aw_addr == sbs_pkg::REG_PDATA) begin
      prog_mem[paddr] <= w_data[WW-1:0];
    end
  end

  // read channel: answer one clock after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= sbs_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= sbs_pkg::RESP_OKAY;
        s_axi_rdata   <= '0;
        if (s_axi_araddr == sbs_pkg::REG_CTRL) begin
          s_axi_rdata[1:0] <= ctrl;
        end else if (s_axi_araddr == sbs_pkg::REG_STAT) begin
          s_axi_rdata <= {5'h00, tmr, 11'h000, running, pc};
        end else if (s_axi_araddr == sbs_pkg::REG_GRAY) begin
          s_axi_rdata[SHIFT_W-1:0] <= gray_sr;
        end else if (s_axi_araddr == sbs_pkg::REG_INDEX) begin
          s_axi_rdata[SHIFT_W-1:0] <= index_sr;
        end else if (s_axi_araddr == sbs_pkg::REG_PADDR) begin
          s_axi_rdata[AW-1:0] <= paddr;
        end else if (s_axi_araddr == sbs_pkg::REG_PDATA) begin
          s_axi_rdata[WW-1:0] <= prog_mem[paddr];
        end else begin
          s_axi_rresp <= sbs_pkg::RESP_SLVERR;
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_word_start;
    first && running;
  endsequence

  sequence s_timeout;
    running && ctrl[0] && tmr == '0 && !cond.take;
  endsequence

  AST_SEL1_FOLLOWS: assert property (running |-> extra_select_one_pin == word[24])
    else $error("extra select one pin differs from word");

  AST_WDIS_BLOCKS: assert property (running && word[23] |=> !qualified_write_gate)
    else $error("write gate passed while write disabled");

  AST_GRAY_SHIFT: assert property (running && word[22] && sync_bit_clock
    |=> gray_sr == {$past(gray_sr[SHIFT_W-2:0]), $past(sync_bit_data)})
    else $error("gray register did not shift");

  AST_INDEX_HOLD: assert property (!(running && word[21]) |=> $stable(index_sr))
    else $error("index register moved outside window");

  AST_SECT_FOLLOWS: assert property (running |-> servo_sector_pin == word[20])
    else $error("servo sector pin differs from word");

  AST_ACQ_ONCE: assert property (acq_start |-> word[19] ##1 !acq_start)
    else $error("acquisition start not a single rising pulse");

  AST_STEP_ON_TIMEOUT: assert property (s_timeout |=> first && pc == $past(pc) + 5'h01)
    else $error("no sequential step at timeout");

  AST_TIMER_DOWN: assert property (running && ctrl[0] && tmr != '0 && !cond.take
    |=> tmr == $past(tmr) - 10'h001)
    else $error("state timer did not count down");

  AST_TARGET: assert property (running && ctrl[0] && cond.take
    |=> pc == $past(word[14:10]))
    else $error("branch target not loaded");

  AST_TIMER_LOAD: assert property (s_word_start |-> tmr == word[9:0])
    else $error("timer not loaded from word");

  AST_IMMEDIATE: assert property (running && ctrl[0] && word[18:16] == 3'h7 |=> first)
    else $error("unconditional branch waited");

  AST_NEVER: assert property (running && word[18:16] == 3'h0 |-> !cond.take)
    else $error("type never took a branch");

  AST_IRQ: assert property (s_word_start |-> dsp_irq == word[15])
    else $error("interrupt does not match word");
endmodule // sbs_word_exec

// ===== testbench/sbs_far_model.sv
/*
 far side model: data synchronizer bit clock and data, unqualified write gate.
 assumes one clock, inputs changed just after the rising edge.
*/
`timescale 1ns/1ps
module sbs_far_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic en,
  output logic      sync_bit_clock,
  output logic      sync_bit_data,
  output logic      write_gate_req
);
  initial begin
    sync_bit_clock = 1'b0;
    sync_bit_data  = 1'b0;
    write_gate_req = 1'b0;
  end

  // bit clock only inside frames; pulses never back to back
  always @(posedge aclk) begin
    write_gate_req <= 1'($urandom % 2);
    if (en && aresetn && !sync_bit_clock && ($urandom % 3) == 0) begin
      sync_bit_clock <= 1'b1;
      sync_bit_data  <= 1'($urandom % 2);
    end else begin
      sync_bit_clock <= 1'b0;
      // data is not held outside the pulse
      sync_bit_data  <= ~sync_bit_data;
    end
  end
endmodule // sbs_far_model

// ===== testbench/tb_servo_burst_sequencer_word_exec.sv
/*
 self-checking bench for the word execution block: registers, shift windows, branches.
 assumes the far side model and an axi4-lite master built from tasks.
*/
`timescale 1ns/1ps
module tb_servo_burst_sequencer_word_exec;
  logic        aclk = 1'b0, aresetn = 1'b0, en = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        miss = 1'b0, win = 1'b0, mark = 1'b0, flag = 1'b0;
  logic        bclk, bdat, wgr, sel1, qwg, sect, acq, irq;
  int          mismatches = 0, compares = 0, hi_cnt = 0, s_w = 0;
  logic        arm = 1'b0, got = 1'b0, s_sect, s_irq, s_acq;
  logic        trk = 1'b0, blk = 1'b0, pv = 1'b0, p_wgr, p_sel1;
  logic [15:0] exp_sr = 16'h0;

  initial forever #2.5 aclk = ~aclk;

  sbs_word_exec dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .missing_mark_latch(miss), .search_window(win), .servo_timing_mark(mark),
    .flag_bit(flag), .sync_bit_clock(bclk), .sync_bit_data(bdat), .write_gate_req(wgr),
    .extra_select_one_pin(sel1), .qualified_write_gate(qwg), .servo_sector_pin(sect),
    .acq_start(acq), .dsp_irq(irq));

  sbs_far_model far (.aclk(aclk), .aresetn(aresetn), .en(en), .sync_bit_clock(bclk),
    .sync_bit_data(bdat), .write_gate_req(wgr));

  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task hang(input string n);
    mismatches++;
    $display("Error %s expected done seen timeout", n);
    end_of_test();
  endtask

  task chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task chk_r(input string n, input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   i;
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    i  = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (++i > 100) hang("write_address_data");
      if (!ga && awready === 1'b1) begin ga = 1'b1; awvalid <= 1'b0; end
      if (!gw && wready === 1'b1) begin gw = 1'b1; wvalid <= 1'b0; end
    end
    do begin
      @(posedge aclk);
      if (++i > 200) hang("write_response");
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    i = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (++i > 100) hang("read_address");
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (++i > 200) hang("read_data");
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task wait_got;
    int n;
    n = 0;
    while (got !== 1'b1) begin
      @(posedge aclk);
      if (++n > 2000) hang("word_end");
    end
  endtask

  // f = {xs1, wdis, gray, idx, servo_sector_pin, acq, irq}
  function automatic logic [24:0] mk(input logic [6:0] f, input logic [2:0] bt,
                                     input logic [4:0] ba, input logic [9:0] tl);
    return {f[6:1], bt, f[0], ba, tl};
  endfunction

  // v = {missing latch, window, mark, flag, branch bit}
  function automatic logic take(input logic [2:0] bt, input logic [4:0] v);
    case (bt)
      3'h0: return 1'b0;
      3'h1: return v[4];
      3'h2: return v[3];
      3'h3: return v[3] & v[2];
      3'h4: return v[1];
      3'h5: return v[0];
      3'h6: return v[0];
      default: return 1'b1;
    endcase
  endfunction

  // first stretch of the select pin and the cycle right after it
  always @(negedge aclk) begin
    if (!arm) begin
      hi_cnt = 0;
      got    = 1'b0;
    end else if (sel1 === 1'b1) hi_cnt = hi_cnt + 1;
    else if (hi_cnt != 0 && !got) begin
      got = 1'b1; s_w = hi_cnt; s_sect = sect; s_irq = irq; s_acq = acq;
    end
  end

  // bit clocks only count while the select-marked window word runs
  always @(posedge aclk) begin
    if (!trk) exp_sr <= 16'h0;
    else if (sel1 === 1'b1 && bclk === 1'b1) exp_sr <= {exp_sr[14:0], bdat};
  end

  // gate follows request one cycle late, blocked in the write-disabled window word
  always @(negedge aclk) begin
    if (pv) chk_w("qualified_write_gate", {31'h0, p_wgr & ~(p_sel1 & blk)},
                  {31'h0, qwg});
    p_wgr  = wgr;
    p_sel1 = sel1;
    pv    = aresetn;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] eg;
    logic [4:0]  v;
    logic [2:0]  bt;
    logic        tk;
    int          i, l, ew;
    logic [7:0]  ra [5];
    ra = '{sbs_pkg::REG_CTRL, sbs_pkg::REG_STAT, sbs_pkg::REG_GRAY, sbs_pkg::REG_INDEX,
           sbs_pkg::REG_PADDR};
    void'($urandom(75));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(ra[i], d, r);
      chk_w("reset_value", 32'h0, d);
      chk_r("rresp", sbs_pkg::RESP_OKAY, r);
    end
    rd(8'h18, d, r);
    chk_r("unmapped_rresp", sbs_pkg::RESP_SLVERR, r);
    chk_w("unmapped_rdata", 32'h0, d);
    wr(8'h18, 32'hffffffff, r);
    chk_r("unmapped_bresp", sbs_pkg::RESP_SLVERR, r);
    wr(sbs_pkg::REG_PADDR, 32'h5, r);
    rd(sbs_pkg::REG_PADDR, d, r);
    chk_w("program_address", 32'h5, d);
    wr(sbs_pkg::REG_PDATA, 32'hffffffff, r);
    rd(sbs_pkg::REG_PADDR, d, r);
    chk_w("program_address_step", 32'h6, d);
    wr(sbs_pkg::REG_PADDR, 32'h5, r);
    rd(sbs_pkg::REG_PDATA, d, r);
    chk_w("program_word", 32'h01ffffff, d);
    $display("test registers done");

    // window words run long so the last bits land
    for (i = 0; i < 2; i++) begin
      blk <= (i == 0);
      arm <= 1'b0;
      wr(sbs_pkg::REG_PADDR, 32'h0, r);
      wr(sbs_pkg::REG_PDATA, 32'(mk(i ? 7'h48 : 7'h70, 3'h0, 5'h0, 10'd40)), r);
      wr(sbs_pkg::REG_PDATA, 32'(mk(7'h00, 3'h7, 5'h1, 10'd1)), r);
      trk <= 1'b1;
      en  <= 1'b1;
      arm <= 1'b1;
      wr(sbs_pkg::REG_CTRL, 32'h1, r);
      wait_got();
      chk_w("window_cycles", 32'd41, s_w);
      rd(sbs_pkg::REG_STAT, d, r);
      chk_w("status", 32'h00020021, d);
      wr(sbs_pkg::REG_CTRL, 32'h0, r);
      en <= 1'b0;
      repeat (3) @(posedge aclk);
      if (i == 0) eg = exp_sr;
      rd(sbs_pkg::REG_GRAY, d, r);
      chk_w("gray_shift", {16'h0, eg}, d);
      rd(sbs_pkg::REG_INDEX, d, r);
      chk_w("index_shift", {16'h0, i ? exp_sr : 16'h0}, d);
      trk <= 1'b0;
    end
    blk <= 1'b0;
    $display("test shift windows done");

    wr(sbs_pkg::REG_PADDR, 32'h1, r);
    wr(sbs_pkg::REG_PDATA, 32'(mk(7'h04, 3'h0, 5'h0, 10'd3)), r);
    wr(sbs_pkg::REG_PDATA, 32'(mk(7'h03, 3'h7, 5'h0, 10'd1)), r);
    for (i = 0; i < 24; i++) begin
      bt = 3'(i / 3);
      l  = (i % 3 == 0) ? 1 : 1 + $urandom % 12;
      v  = 5'($urandom);
      tk = take(bt, v);
      ew = (bt == 3'h7 || (tk && bt != 3'h6)) ? 1 : l + 1;
      {miss, win, mark, flag} <= v[4:1];
      arm <= 1'b0;
      wr(sbs_pkg::REG_PADDR, 32'h0, r);
      wr(sbs_pkg::REG_PDATA, 32'(mk(7'h40, bt, 5'h2, 10'(l))), r);
      arm <= 1'b1;
      wr(sbs_pkg::REG_CTRL, {30'h0, v[0], 1'b1}, r);
      chk_r("ctrl_bresp", sbs_pkg::RESP_OKAY, r);
      wait_got();
      chk_w("word_cycles", ew, s_w);
      chk_w("sequential_word", {31'h0, ~tk}, {31'h0, s_sect});
      chk_w("target_irq", {31'h0, tk}, {31'h0, s_irq});
      chk_w("acq_start", {31'h0, tk}, {31'h0, s_acq});
      wr(sbs_pkg::REG_CTRL, 32'h0, r);
    end
    $display("test branch types done");
    end_of_test();
  end
endmodule // tb_servo_burst_sequencer_word_exec
